// ==== shared/mlt_map.svh ====
// mlt_map.svh: register offsets, field positions, reset values and timing
// counts of the address learning table.
// assumes inclusion by bare name; definitions only.
`ifndef MLT_MAP_SVH
`define MLT_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define MLT_CTRL_OFS      12'h000  // bit0 aging disable
`define MLT_AGE_OFS       12'h004  // aging time in seconds
`define MLT_LMODE_OFS     12'h008  // two bits per port
`define MLT_ADDR_LO_OFS   12'h00C  // address bits 31:0
`define MLT_ADDR_HI_OFS   12'h010  // 27:16 vlan, 15:0 address 47:32
`define MLT_MEMB_OFS      12'h014  // member ports
`define MLT_CMD_OFS       12'h018  // command, write starts it
`define MLT_STAT_OFS      12'h01C  // status and readout entry info
`define MLT_COUNT_OFS     12'h020  // valid entry count

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define MLT_CTRL_AGE_OFF  0
`define MLT_AGE_RST       32'h0000_012C
`define MLT_AGE_MIN       32'h0000_000A
`define MLT_AGE_MAX       32'h000F_4240
`define MLT_STAT_BUSY     0
`define MLT_STAT_FOUND    1
`define MLT_STAT_STATIC   2
`define MLT_STAT_FULL     3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MLT_CLK_HZ        50000000
`define MLT_TICK_S        1

`endif

// ==== shared/mlt_pkg.sv ====
// mlt_pkg.sv: types shared by the address learning table.
// assumes mlt_map.svh for numbers.
package mlt_pkg;

  // per-port learning behaviour
  typedef enum logic [1:0] {
    MLT_LEARN_AUTO   = 2'b00,
    MLT_LEARN_OFF    = 2'b01,
    MLT_LEARN_SECURE = 2'b10
  } mlt_lmode_type;

  // software commands written to the command register
  typedef enum logic [1:0] {
    MLT_CMD_ADD_STATIC = 2'b00,
    MLT_CMD_DELETE     = 2'b01,
    MLT_CMD_READ_NEXT  = 2'b10,
    MLT_CMD_FLUSH_DYN  = 2'b11
  } mlt_cmd_type;

  // one table entry
  typedef struct packed {
    logic        valid;
    logic        is_static;
    logic [11:0] vlan;
    logic [47:0] addr;
    logic [15:0] members;
    logic [19:0] age;
  } mlt_entry_type;

  // frame header offered by ingress
  typedef struct packed {
    logic [3:0]  port;
    logic [11:0] vlan;
    logic [47:0] source_station_address;
    logic [47:0] dest_addr;
  } mlt_frame_type;

  // forwarding decision
  typedef struct packed {
    logic        drop;
    logic        hit;
    logic [15:0] members;
  } mlt_fwd_type;

endpackage

// ==== src/mlt_table.sv ====
// mlt_table.sv: address learning and lookup table with aging and apb access.
// assumes ingress offers one frame header per valid pulse on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "mlt_map.svh"

module mlt_table
  import mlt_pkg::*;
#(
  parameter int          DEPTH      = 64,
  parameter int          NPORTS     = 16,
  parameter int unsigned TICK_CYCLES = `MLT_CLK_HZ * `MLT_TICK_S
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          frame_valid,
  input  wire mlt_frame_type frame_hdr,
  output mlt_fwd_type        fwd_q,
  output logic               fwd_valid_q
);

  // ----------------------------------------------------------------------
  // storage and configuration
  // ----------------------------------------------------------------------
  localparam int IW = $clog2(DEPTH);

  mlt_entry_type       tab_q [DEPTH];        // table entries
  logic                age_off_q;            // aging disable
  logic [19:0]         age_time_q;           // seconds
  logic [31:0]         lmode_q;              // two bits per port
  logic [47:0]         key_addr_q;           // command key address
  logic [11:0]         key_vlan_q;           // command key vlan
  logic [15:0]         key_memb_q;           // command members
  logic [3:0]          stat_q;               // status bits
  logic [31:0]         tick_cnt_q;           // one-second divider
  logic                tick_q;               // one-second pulse
  logic                cmd_rd_done_q;        // readout result ready
  logic [IW-1:0]       rd_idx_q;             // readout entry index

  // key match function, used for source, destination and commands
  function automatic logic key_hit(mlt_entry_type e, logic [11:0] v, logic [47:0] a);
    key_hit = e.valid && (e.vlan == v) && (e.addr == a);
  endfunction

  // key ordering function for readout: {vlan,addr} strictly greater
  function automatic logic key_gt(mlt_entry_type e, logic [11:0] v, logic [47:0] a);
    key_gt = e.valid && ({e.vlan, e.addr} > {v, a});
  endfunction

  // ----------------------------------------------------------------------
  // combinational search
  // ----------------------------------------------------------------------
  logic [DEPTH-1:0] src_hit, dst_hit, key_hit_v, nxt_v;
  logic             src_found, dst_found, free_found, key_found, nxt_found;
  logic             src_static;
  logic [IW-1:0]    src_idx, free_idx, key_idx, nxt_idx;
  logic [15:0]      dst_memb;
  logic [59:0]      nxt_key;
  logic [IW:0]      count;

  // lookup against every entry
  always_comb begin
    src_found  = 1'b0;
    dst_found  = 1'b0;
    free_found = 1'b0;
    key_found  = 1'b0;
    nxt_found  = 1'b0;
    src_static = 1'b0;
    src_idx    = '0;
    free_idx   = '0;
    key_idx    = '0;
    nxt_idx    = '0;
    dst_memb   = '0;
    nxt_key    = '1;
    count      = '0;
    for (int i = 0; i < DEPTH; i++) begin
      src_hit[i]   = key_hit(tab_q[i], frame_hdr.vlan, frame_hdr.source_station_address);
      dst_hit[i]   = key_hit(tab_q[i], frame_hdr.vlan, frame_hdr.dest_addr);
      key_hit_v[i] = key_hit(tab_q[i], key_vlan_q, key_addr_q);
      nxt_v[i]     = key_gt(tab_q[i], key_vlan_q, key_addr_q);
      if (tab_q[i].valid) begin
        count = count + 1'b1;
      end
      if (src_hit[i] && !src_found) begin
        src_found  = 1'b1;
        src_idx    = IW'(i);
        src_static = tab_q[i].is_static;
      end
      if (dst_hit[i] && !dst_found) begin
        dst_found = 1'b1;
        dst_memb  = tab_q[i].members;
      end
      if (!tab_q[i].valid && !free_found) begin
        free_found = 1'b1;
        free_idx   = IW'(i);
      end
      if (key_hit_v[i] && !key_found) begin
        key_found = 1'b1;
        key_idx   = IW'(i);
      end
      if (nxt_v[i] && ({tab_q[i].vlan, tab_q[i].addr} < nxt_key)) begin
        nxt_found = 1'b1;
        nxt_idx   = IW'(i);
        nxt_key   = {tab_q[i].vlan, tab_q[i].addr};
      end
    end
  end

  // ----------------------------------------------------------------------
  // per-frame decisions
  // ----------------------------------------------------------------------
  // port mode select
  wire mlt_lmode_type port_mode  = mlt_lmode_type'(lmode_q[{frame_hdr.port, 1'b0} +: 2]);
  wire               sec_drop   = (port_mode == MLT_LEARN_SECURE) && !(src_found && src_static);
  // auto learn, off mode never learns
  wire               do_learn   = frame_valid && (port_mode == MLT_LEARN_AUTO) &&
                                  !src_found && free_found;
  wire               do_refresh = frame_valid && src_found && !src_static;
  wire [15:0]        port_bit   = 16'(1) << frame_hdr.port;

  // apb decode
  wire        apb_wr   = psel && penable && pwrite;
  wire        apb_rd   = psel && !pwrite;
  wire        known    = (paddr <= `MLT_COUNT_OFS) && (paddr[1:0] == 2'b00);
  wire        cmd_go   = apb_wr && (paddr == `MLT_CMD_OFS);
  wire mlt_cmd_type cmd = mlt_cmd_type'(pwdata[1:0]);
  wire [19:0] age_in   = (pwdata < `MLT_AGE_MIN) ? 20'(`MLT_AGE_MIN) :
                         (pwdata > `MLT_AGE_MAX) ? 20'(`MLT_AGE_MAX) : pwdata[19:0];

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;

  // ----------------------------------------------------------------------
  // one-second tick
  // ----------------------------------------------------------------------
  // tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TICK_CYCLES - 1);
      tick_cnt_q <= (tick_cnt_q == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_off_q  <= 1'b0;
      age_time_q <= 20'(`MLT_AGE_RST);
      lmode_q    <= 32'h0000_0000;
      key_addr_q <= 48'h0000_0000_0000;
      key_vlan_q <= 12'h000;
      key_memb_q <= 16'h0000;
    end else if (apb_wr) begin
      if (paddr == `MLT_CTRL_OFS)    age_off_q  <= pwdata[`MLT_CTRL_AGE_OFF];
      if (paddr == `MLT_AGE_OFS)     age_time_q <= age_in;
      if (paddr == `MLT_LMODE_OFS)   lmode_q    <= pwdata;
      if (paddr == `MLT_ADDR_LO_OFS) key_addr_q[31:0]  <= pwdata;
      if (paddr == `MLT_ADDR_HI_OFS) begin
        key_addr_q[47:32] <= pwdata[15:0];
        key_vlan_q        <= pwdata[27:16];
      end
      if (paddr == `MLT_MEMB_OFS)    key_memb_q <= pwdata[15:0];
    end else if (stat_q[`MLT_STAT_FOUND] && cmd_rd_done_q) begin
      // readout loads the found entry back into the key registers
      key_addr_q <= tab_q[rd_idx_q].addr;
      key_vlan_q <= tab_q[rd_idx_q].vlan;
      key_memb_q <= tab_q[rd_idx_q].members;
    end
  end

  // ----------------------------------------------------------------------
  // table update: commands, learning, aging
  // ----------------------------------------------------------------------

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        tab_q[i] <= '0;
      end
      stat_q        <= 4'h0;
      cmd_rd_done_q <= 1'b0;
      rd_idx_q      <= '0;
    end else begin
      cmd_rd_done_q <= 1'b0;
      // aging countdown on tick, skipped when disabled
      if (tick_q && !age_off_q) begin
        for (int i = 0; i < DEPTH; i++) begin
          if (tab_q[i].valid && !tab_q[i].is_static) begin
            if (tab_q[i].age <= 20'h0_0001) tab_q[i].valid <= 1'b0;
            else                            tab_q[i].age   <= tab_q[i].age - 1'b1;
          end
        end
      end
      if (do_refresh) tab_q[src_idx].age <= age_time_q;
      // learn new dynamic entry, type dynamic
      if (do_learn && !cmd_go) begin
        tab_q[free_idx] <= '{valid: 1'b1, is_static: 1'b0, vlan: frame_hdr.vlan,
                             addr: frame_hdr.source_station_address,
                             members: port_bit, age: age_time_q};
      end
      stat_q[`MLT_STAT_FULL] <= !free_found;
      if (cmd_go) begin
        unique case (cmd)
          MLT_CMD_ADD_STATIC: begin
            if (key_found || free_found) begin
              tab_q[key_found ? key_idx : free_idx] <= '{valid: 1'b1, is_static: 1'b1,
                  vlan: key_vlan_q, addr: key_addr_q, members: key_memb_q, age: 20'h0_0000};
            end
            stat_q[`MLT_STAT_FOUND] <= key_found || free_found;
          end
          MLT_CMD_DELETE: begin
            if (key_found) tab_q[key_idx].valid <= 1'b0;
            stat_q[`MLT_STAT_FOUND] <= key_found;
          end
          MLT_CMD_READ_NEXT: begin
            stat_q[`MLT_STAT_FOUND]  <= nxt_found;
            stat_q[`MLT_STAT_STATIC] <= tab_q[nxt_idx].is_static;
            rd_idx_q                 <= nxt_idx;
            cmd_rd_done_q            <= 1'b1;
          end
          MLT_CMD_FLUSH_DYN: begin
            for (int i = 0; i < DEPTH; i++) begin
              if (!tab_q[i].is_static) tab_q[i].valid <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // forwarding result
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_q       <= '0;
      fwd_valid_q <= 1'b0;
    end else begin
      fwd_valid_q  <= frame_valid;
      fwd_q.drop   <= frame_valid && sec_drop;
      fwd_q.hit    <= frame_valid && dst_found;
      fwd_q.members <= dst_found ? dst_memb : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // apb read mux
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    unique case (paddr)
      `MLT_CTRL_OFS:    rd_mux = {31'h0, age_off_q};
      `MLT_AGE_OFS:     rd_mux = {12'h000, age_time_q};
      `MLT_LMODE_OFS:   rd_mux = lmode_q;
      `MLT_ADDR_LO_OFS: rd_mux = key_addr_q[31:0];
      `MLT_ADDR_HI_OFS: rd_mux = {4'h0, key_vlan_q, key_addr_q[47:32]};
      `MLT_MEMB_OFS:    rd_mux = {16'h0000, key_memb_q};
      `MLT_STAT_OFS:    rd_mux = {28'h000_0000, stat_q};
      `MLT_COUNT_OFS:   rd_mux = 32'(count);
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered during setup so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (apb_rd && !penable) prdata <= rd_mux;
  end

endmodule // mlt_table
`default_nettype wire

// ==== testbench/mlt_table_properties.sv ====
// mlt_table_properties.sv: port checks of the learning table.
// assumes it is bound to every mlt_table instance.
`timescale 1ns/1ps
`default_nettype none
module mlt_table_properties
  import mlt_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          frame_valid,
  input wire mlt_frame_type frame_hdr,
  input wire mlt_fwd_type   fwd_q,
  input wire logic          fwd_valid_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // register bus answers
  // ----------------------------------------------------------------
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (psel && penable && paddr > 12'h020 |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  a_err_unaligned: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access not refused");
  a_err_mapped: assert property (psel && penable && paddr <= 12'h020 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_err_idle: assert property (!psel |-> !pslverr)
    else $error("error flag while idle");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  // ----------------------------------------------------------------
  // forwarding answers
  // ----------------------------------------------------------------
  a_fwd_answer: assert property (frame_valid |=> fwd_valid_q)
    else $error("no decision after frame");
  a_fwd_only: assert property (!frame_valid |=> !fwd_valid_q)
    else $error("decision without frame");
  a_miss_nomemb: assert property (fwd_valid_q && !fwd_q.hit |-> fwd_q.members == 16'h0000)
    else $error("members on a destination miss");
  a_drop_framed: assert property (fwd_q.drop |-> fwd_valid_q)
    else $error("drop without a decision");
  // main scenarios reached
  c_frame: cover property (frame_valid ##1 fwd_valid_q && fwd_q.hit);
  c_drop: cover property (fwd_valid_q && fwd_q.drop);
  c_error: cover property (psel && penable && pslverr);
endmodule // mlt_table_properties
bind mlt_table mlt_table_properties i_mlt_table_properties (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_valid, .frame_hdr, .fwd_q,
  .fwd_valid_q);
`default_nettype wire

// ==== testbench/mlt_ingress_model.sv ====
// mlt_ingress_model.sv: ingress side offering frame headers to the table.
// assumes one clock shared with the table; headers are taken one per pulse.
`timescale 1ns/1ps
`default_nettype none
module mlt_ingress_model
  import mlt_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          fwd_valid_q,
  input  wire mlt_fwd_type   fwd_q,
  output var  logic          frame_valid,
  output var  mlt_frame_type frame_hdr
);
  initial begin
    frame_valid = 1'b0;
    frame_hdr   = '0;
  end
  // one header, then the decision one cycle after it
  task automatic send(input logic [3:0] p, input logic [11:0] v, input logic [47:0] s,
                      input logic [47:0] d, output logic ok, output mlt_fwd_type f);
    @(posedge pclk);
    frame_valid <= 1'b1;
    frame_hdr   <= {p, v, s, d};
    @(posedge pclk);
    frame_valid <= 1'b0;
    frame_hdr   <= ~frame_hdr;  // idle header is garbage, never the last one
    @(posedge pclk);
    ok = fwd_valid_q;
    f  = fwd_q;
  endtask
endmodule // mlt_ingress_model
`default_nettype wire

// ==== testbench/tb.sv ====
// tb.sv: self-checking bench of the learning table against a queue model.
// assumes mlt_map.svh on the include path and a short one-second tick.
`timescale 1ns/1ps
`default_nettype none
`include "mlt_map.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  import mlt_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_valid;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic          fwd_valid_q, err, ok;
  mlt_frame_type frame_hdr;
  mlt_fwd_type   fwd_q, f;
  int            err_count, tests_run, cyc, idx;
  integer        seed = 32'hfcb1b00e;
  logic [59:0]   mkey [$];  // model keys {vlan, addr}
  logic [15:0]   mmem [$];  // model members
  bit            mstat [$]; // model static flag
  mlt_lmode_type lm [16];   // model learning modes
  logic [47:0]   sa, src, prev;
  logic [11:0]   vl;
  logic [59:0]   k;

  mlt_table #(.TICK_CYCLES(10)) i_mlt_table (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid), .frame_hdr(frame_hdr),
    .fwd_q(fwd_q), .fwd_valid_q(fwd_valid_q));
  mlt_ingress_model i_mlt_ingress_model (.pclk(pclk), .fwd_valid_q(fwd_valid_q),
    .fwd_q(fwd_q), .frame_valid(frame_valid), .frame_hdr(frame_hdr));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  function automatic int mfind(logic [59:0] key);
    foreach (mkey[i]) if (mkey[i] === key) return i;
    return -1;
  endfunction
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic key_wr(input logic [59:0] kk, input mlt_cmd_type c);
    apb(1'b1, `MLT_ADDR_LO_OFS, kk[31:0]);
    apb(1'b1, `MLT_ADDR_HI_OFS, {4'h0, kk[59:32]});
    apb(1'b1, `MLT_CMD_OFS, 32'(c));
  endtask
  task automatic count_chk();
    apb(1'b0, `MLT_COUNT_OFS, 32'h0000_0000);
    `CHK("count", 32'(mkey.size()), rd)
  endtask
  // frame with model lookup and learning
  task automatic frame(input logic [3:0] p, input logic [11:0] v, input logic [47:0] s,
                       input logic [47:0] d);
    int si, di;
    logic ed;
    si = mfind({v, s});
    di = mfind({v, d});
    ed = (lm[p] == MLT_LEARN_SECURE) && (si < 0 || !mstat[si]);
    i_mlt_ingress_model.send(p, v, s, d, ok, f);
    `CHK("fwd_valid", 1'b1, ok)
    `CHK("drop", ed, f.drop)
    if (!ed) begin
      `CHK("hit", di >= 0, f.hit)
      if (di >= 0) `CHK("members", mmem[di], f.members)
    end
    // auto learns unknown sources only; off and secure add nothing
    if (lm[p] == MLT_LEARN_AUTO && si < 0) begin
      mkey.push_back({v, s});
      mmem.push_back(16'h0001 << p);
      mstat.push_back(1'b0);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    presetn = 1'b0; cyc = 0; err_count = 0; tests_run = 0;
    foreach (lm[i]) lm[i] = MLT_LEARN_AUTO;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `MLT_AGE_OFS, 32'h0000_0000);
    `CHK("age_reset", `MLT_AGE_RST, rd)
    count_chk();
    apb(1'b0, `MLT_LMODE_OFS, 32'h0000_0000);
    `CHK("lmode_reset", 32'h0000_0000, rd)
    apb(1'b0, 12'h040, 32'h0000_0000);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_rd", 32'h0000_0000, rd)
    apb(1'b1, `MLT_AGE_OFS, 32'h0000_0005);
    apb(1'b0, `MLT_AGE_OFS, 32'h0000_0000);
    `CHK("age_clamp", `MLT_AGE_MIN, rd)
    vl = 12'($random(seed)) | 12'h001;
    sa = {16'($random(seed)), 32'($random(seed))};
    // static entry added before a port goes secure
    apb(1'b1, `MLT_MEMB_OFS, 32'h0000_00F0);
    key_wr({vl, sa}, MLT_CMD_ADD_STATIC);
    mkey.push_back({vl, sa}); mmem.push_back(16'h00F0); mstat.push_back(1'b1);
    apb(1'b1, `MLT_LMODE_OFS, 32'h0000_0024);
    lm[1] = MLT_LEARN_OFF;
    lm[2] = MLT_LEARN_SECURE;
    prev = sa;
    for (int i = 0; i < 9; i++) begin
      src = {16'($random(seed)), 32'($random(seed))};
      if (i == 5) src = sa;
      frame(4'(i % 3), vl, src, (i % 2) ? prev : sa);
      prev = src;
    end
    frame(4'd1, vl ^ 12'h001, prev, sa);
    count_chk();
    // readout from key zero returns the smallest key
    key_wr(60'h0, MLT_CMD_READ_NEXT);
    k = '1;
    foreach (mkey[i]) if (mkey[i] < k) begin k = mkey[i]; idx = i; end
    apb(1'b0, `MLT_ADDR_HI_OFS, 32'h0000_0000);
    `CHK("read_hi", {4'h0, k[59:32]}, rd)
    apb(1'b0, `MLT_ADDR_LO_OFS, 32'h0000_0000);
    `CHK("read_lo", k[31:0], rd)
    apb(1'b0, `MLT_MEMB_OFS, 32'h0000_0000);
    `CHK("read_memb", 32'(mmem[idx]), rd)
    apb(1'b0, `MLT_STAT_OFS, 32'h0000_0000);
    `CHK("read_found", 1'b1, rd[`MLT_STAT_FOUND])
    `CHK("read_static", mstat[idx], rd[`MLT_STAT_STATIC])
    // aging off keeps entries, aging on clears dynamic ones
    apb(1'b1, `MLT_CTRL_OFS, 32'h0000_0001);
    repeat (300) @(posedge pclk);
    count_chk();
    apb(1'b1, `MLT_CTRL_OFS, 32'h0000_0000);
    repeat (300) @(posedge pclk);
    for (int i = mkey.size() - 1; i >= 0; i--)
      if (!mstat[i]) begin mkey.delete(i); mmem.delete(i); mstat.delete(i); end
    count_chk();
    // flush drops learned entries and keeps the static one
    frame(4'd0, vl, prev, sa);
    count_chk();
    apb(1'b1, `MLT_CMD_OFS, 32'(MLT_CMD_FLUSH_DYN));
    for (int i = mkey.size() - 1; i >= 0; i--) begin
      if (!mstat[i]) begin
        mkey.delete(i);
        mmem.delete(i);
        mstat.delete(i);
      end
    end
    count_chk();
    key_wr({vl, sa}, MLT_CMD_DELETE);
    idx = mfind({vl, sa});
    mkey.delete(idx); mmem.delete(idx); mstat.delete(idx);
    count_chk();
    frame(4'd1, vl, prev, sa);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
